// File: core/riss_ref_decode.sv
// Per-synthesizer reference decoder: mode code plus select pin to source
`timescale 1ns/1ns
module riss_ref_decode
    import riss_pkg::*;
#(
    parameter bit PIN_MID_AUTO = 1'b0
)
(
    input wire logic [1:0] refSelect,
    input wire logic [1:0] refChoicePin,
    input wire logic primaryAvailable,
    output logic useSecondary,
    output logic autoMode
);

    always_comb
    begin
        autoMode = 1'b0;
        useSecondary = 1'b0;
        case (refSelect)
            RISS_SEL_AUTO:
            begin
                autoMode = 1'b1;
            end
            RISS_SEL_PIN:
            begin
                if (refChoicePin == RISS_PIN_HIGH)
                begin
                    autoMode = 1'b1; // [RULE_09] [RULE_10]
                end
                else if (refChoicePin == RISS_PIN_MID)
                begin
                    // Synth A goes automatic on mid, synth B picks secondary
                    autoMode = PIN_MID_AUTO; // [RULE_10]
                    useSecondary = !PIN_MID_AUTO; // [RULE_09]
                end
                else
                begin
                    // Low: A keeps primary, B takes secondary
                    useSecondary = !PIN_MID_AUTO; // [RULE_09] [RULE_10]
                end
            end
            RISS_SEL_PRI:
            begin
                useSecondary = 1'b0;
            end
            RISS_SEL_SEC:
            begin
                useSecondary = 1'b1;
            end
            default:
            begin
                useSecondary = 1'b0;
            end
        endcase
        // Automatic: primary preferred, secondary only as fallback
        if (autoMode)
        begin
            useSecondary = !primaryAvailable; // [RULE_08]
        end
    end

endmodule

// File: core/riss_top.sv
// Reference input select and status edge-rate control, Avalon-MM slave
//
// Operation
// [RULE_01] Bits 3:2 set second status edge rate
// [RULE_02] Bits 1:0 set first status edge rate
// [RULE_03] Host must not write codes 1 or 3
// [RULE_04] Bits 7:6 set secondary buffer mode, reset 2
// [RULE_05] Bits 5:4 set primary buffer mode, reset 1
// [RULE_06] Bits 3:2 pick synth B reference, reset 1
// [RULE_07] Bits 1:0 pick synth A reference, reset 1
// [RULE_08] Automatic mode prefers primary, secondary fallback
// [RULE_09] Synth B pin: low/mid secondary, high auto
// [RULE_10] Synth A pin: low primary, mid/high auto
// [RULE_11] Slew upper bits ignored, read zero
`timescale 1ns/1ns
module riss_top
    import riss_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic [1:0] refChoicePin,
    input wire logic primaryAvailable,
    output logic [1:0] firstStatusEdgeRate,
    output logic [1:0] secondStatusEdgeRate,
    output logic firstStatusSlow,
    output logic secondStatusSlow,
    output logic [1:0] primaryBufferMode,
    output logic [1:0] secondaryBufferMode,
    output logic primaryBufferOn,
    output logic secondaryBufferOn,
    output logic synthAUseSecondary,
    output logic synthBUseSecondary,
    output logic synthAAuto,
    output logic synthBAuto
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [9:0] addr,
        input logic [9:0] target);
        return (addr == target);
    endfunction

    // Every field of both registers is two bits wide
    function automatic logic [1:0] field_of(input logic [31:0] word,
        input int lsb);
        return word[lsb +: 2];
    endfunction

    // Reserved codes count as fast, the safe drive strength
    function automatic logic edge_is_slow(input logic [1:0] code);
        return (code == RISS_EDGE_SLOW);
    endfunction

    // ------------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------------
    // One wait cycle per access: the answer is registered, which keeps
    // read data from flip-flops at the cost of one cycle of latency.
    logic ackPending;
    logic busReq;
    logic accept;
    logic hitSlew;
    logic hitInsel;
    logic hitState;
    logic hitAny;

    assign busReq = avs_read || avs_write;
    assign accept = busReq && ackPending;
    assign avs_waitrequest = busReq && !ackPending;
    assign hitSlew = addr_hit(avs_address, RISS_ADDR_SLEW);
    assign hitInsel = addr_hit(avs_address, RISS_ADDR_INSEL);
    assign hitState = addr_hit(avs_address, RISS_ADDR_STATE);
    assign hitAny = hitSlew || hitInsel || hitState;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ackPending <= 1'b0;
        end
        else if (accept)
        begin
            ackPending <= 1'b0;
        end
        else if (busReq)
        begin
            ackPending <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Status edge-rate register
    // ------------------------------------------------------------------
    logic slewWrite;
    assign slewWrite = accept && avs_write && hitSlew && avs_byteenable[0];

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            secondStatusEdgeRate <= RISS_SLEW_RESET;
            firstStatusEdgeRate <= RISS_SLEW_RESET;
        end
        else if (slewWrite)
        begin
            // Reserved codes are stored as written; host keeps off them
            secondStatusEdgeRate <=
                field_of(avs_writedata, RISS_SLEW_B_LSB); // [RULE_01] [RULE_03]
            firstStatusEdgeRate <=
                field_of(avs_writedata, RISS_SLEW_A_LSB); // [RULE_02]
        end
    end

    // Slow edges only for code 2
    assign secondStatusSlow =
        edge_is_slow(secondStatusEdgeRate); // [RULE_01]
    assign firstStatusSlow =
        edge_is_slow(firstStatusEdgeRate); // [RULE_02]

    // ------------------------------------------------------------------
    // Input select register
    // ------------------------------------------------------------------
    logic inselWrite;
    logic [1:0] synthBRefSelect;
    logic [1:0] synthARefSelect;
    assign inselWrite = accept && avs_write && hitInsel && avs_byteenable[0];

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            secondaryBufferMode <= RISS_SEC_MODE_RESET; // [RULE_04]
            primaryBufferMode <= RISS_PRI_MODE_RESET; // [RULE_05]
        end
        else if (inselWrite)
        begin
            secondaryBufferMode <=
                field_of(avs_writedata, RISS_SEC_MODE_LSB); // [RULE_04]
            primaryBufferMode <=
                field_of(avs_writedata, RISS_PRI_MODE_LSB); // [RULE_05]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            synthBRefSelect <= RISS_SEL_RESET; // [RULE_06]
            synthARefSelect <= RISS_SEL_RESET; // [RULE_07]
        end
        else if (inselWrite)
        begin
            synthBRefSelect <=
                field_of(avs_writedata, RISS_SELB_LSB); // [RULE_06]
            synthARefSelect <=
                field_of(avs_writedata, RISS_SELA_LSB); // [RULE_07]
        end
    end

    assign secondaryBufferOn =
        (secondaryBufferMode != RISS_BUF_OFF); // [RULE_04]
    // Primary has no crystal mode: codes 2 and 3 both switch it off
    assign primaryBufferOn =
        (primaryBufferMode == RISS_BUF_SE) ||
        (primaryBufferMode == RISS_BUF_DIFF); // [RULE_05]

    // ------------------------------------------------------------------
    // Reference decode for both synthesizers
    // ------------------------------------------------------------------
    logic synthAUseSec;
    logic synthBUseSec;
    logic synthAAutoC;
    logic synthBAutoC;

    riss_ref_decode #(
        .PIN_MID_AUTO(1'b1)
    ) u_synth_a (
        .refSelect(synthARefSelect), // [RULE_07] [RULE_10]
        .refChoicePin(refChoicePin),
        .primaryAvailable(primaryAvailable),
        .useSecondary(synthAUseSec),
        .autoMode(synthAAutoC)
    );

    riss_ref_decode #(
        .PIN_MID_AUTO(1'b0)
    ) u_synth_b (
        .refSelect(synthBRefSelect), // [RULE_06] [RULE_09]
        .refChoicePin(refChoicePin),
        .primaryAvailable(primaryAvailable),
        .useSecondary(synthBUseSec),
        .autoMode(synthBAutoC)
    );

    // Registered so the mux controls never glitch on pin transitions
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            synthAUseSecondary <= 1'b0;
            synthAAuto <= 1'b0;
        end
        else
        begin
            synthAUseSecondary <= synthAUseSec; // [RULE_10] [RULE_08]
            synthAAuto <= synthAAutoC; // [RULE_10]
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            synthBUseSecondary <= 1'b0;
            synthBAuto <= 1'b0;
        end
        else
        begin
            synthBUseSecondary <= synthBUseSec; // [RULE_09] [RULE_08]
            synthBAuto <= synthBAutoC; // [RULE_09]
        end
    end

    // ------------------------------------------------------------------
    // Read data and response
    // ------------------------------------------------------------------
    logic [31:0] next_readdata;

    always_comb
    begin
        next_readdata = 32'h00000000;
        if (hitSlew)
        begin
            // Upper nibble always reads zero
            next_readdata[7:0] = {4'h0, secondStatusEdgeRate,
                firstStatusEdgeRate}; // [RULE_11]
        end
        else if (hitInsel)
        begin
            next_readdata[7:0] = {secondaryBufferMode, primaryBufferMode,
                synthBRefSelect, synthARefSelect};
        end
        else if (hitState)
        begin
            next_readdata[3:0] = {synthBAuto, synthBUseSecondary,
                synthAAuto, synthAUseSecondary};
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            avs_readdata <= 32'h00000000;
        end
        else if (busReq && !ackPending && avs_read)
        begin
            avs_readdata <= next_readdata;
        end
    end

    always_comb
    begin
        avs_response = 2'h0;
        if (accept && !hitAny)
        begin
            avs_response = 2'h3;
        end
        else if (accept && avs_write && hitState)
        begin
            avs_response = 2'h2;
        end
    end

endmodule

// File: inc/riss_pkg.sv
// Package: register map, field layout and codes for reference select block
package riss_pkg;

    // ------------------------------------------------------------------
    // Register map (index per 8-bit register; byte address = 4 x index)
    // ------------------------------------------------------------------
    localparam logic [7:0] RISS_IDX_SLEW = 8'h31;
    localparam logic [7:0] RISS_IDX_INSEL = 8'h32;
    localparam logic [9:0] RISS_ADDR_SLEW = {RISS_IDX_SLEW, 2'b00};
    localparam logic [9:0] RISS_ADDR_INSEL = {RISS_IDX_INSEL, 2'b00};
    localparam logic [9:0] RISS_ADDR_STATE = 10'h0D0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RISS_SLEW_B_LSB = 2;
    localparam int RISS_SLEW_A_LSB = 0;
    localparam int RISS_SEC_MODE_LSB = 6;
    localparam int RISS_PRI_MODE_LSB = 4;
    localparam int RISS_SELB_LSB = 2;
    localparam int RISS_SELA_LSB = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [1:0] RISS_SLEW_RESET = 2'h0;
    localparam logic [1:0] RISS_SEC_MODE_RESET = 2'h2;
    localparam logic [1:0] RISS_PRI_MODE_RESET = 2'h1;
    localparam logic [1:0] RISS_SEL_RESET = 2'h1;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [1:0] RISS_EDGE_FAST = 2'h0;
    localparam logic [1:0] RISS_EDGE_SLOW = 2'h2;

    typedef enum logic [1:0] {
        RISS_SEL_AUTO = 2'b00,
        RISS_SEL_PIN = 2'b01,
        RISS_SEL_PRI = 2'b10,
        RISS_SEL_SEC = 2'b11
    } riss_sel_t;

    typedef enum logic [1:0] {
        RISS_PIN_LOW = 2'b00,
        RISS_PIN_MID = 2'b01,
        RISS_PIN_HIGH = 2'b10
    } riss_pin_t;

    localparam logic [1:0] RISS_BUF_SE = 2'h0;
    localparam logic [1:0] RISS_BUF_DIFF = 2'h1;
    localparam logic [1:0] RISS_BUF_XTAL = 2'h2;
    localparam logic [1:0] RISS_BUF_OFF = 2'h3;

endpackage

// File: test/riss_checker.sv
// Checker: bus timing and decode relations of the reference select block
`timescale 1ns/1ns
module riss_checker
    import riss_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire logic [1:0] refChoicePin,
    input wire logic primaryAvailable,
    input wire logic [1:0] firstStatusEdgeRate,
    input wire logic [1:0] secondStatusEdgeRate,
    input wire logic firstStatusSlow,
    input wire logic secondStatusSlow,
    input wire logic [1:0] primaryBufferMode,
    input wire logic [1:0] secondaryBufferMode,
    input wire logic primaryBufferOn,
    input wire logic secondaryBufferOn,
    input wire logic synthAUseSecondary,
    input wire logic synthBUseSecondary,
    input wire logic synthAAuto,
    input wire logic synthBAuto
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Mirror of the select fields, outputs lag it by one edge
    logic [3:0] selMirror;
    wire logic insWr = avs_write && !avs_waitrequest && avs_byteenable[0]
        && avs_address == RISS_ADDR_INSEL;
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            selMirror <= 4'h5;
        else if (insWr)
            selMirror <= avs_writedata[3:0];
    end
    sequence req_start;
        $rose(avs_read || avs_write);
    endsequence
    sequence slew_write;
        avs_write && !avs_waitrequest && avs_byteenable[0]
            && avs_address == RISS_ADDR_SLEW;
    endsequence
    chk_one_wait: assert property (req_start |-> avs_waitrequest
        ##1 !avs_waitrequest) else $error("wait state count wrong");
    chk_slew_store: assert property (slew_write |=>
        {secondStatusEdgeRate, firstStatusEdgeRate}
            == $past(avs_writedata[3:0])) else $error("slew not stored");
    chk_slow_edges: assert property (
        firstStatusSlow == (firstStatusEdgeRate == RISS_EDGE_SLOW)
        && secondStatusSlow == (secondStatusEdgeRate == RISS_EDGE_SLOW))
        else $error("slow flag wrong");
    chk_pri_on: assert property (
        primaryBufferOn == (primaryBufferMode < 2'h2))
        else $error("primary buffer enable wrong");
    chk_sec_on: assert property (
        secondaryBufferOn == (secondaryBufferMode != 2'h3))
        else $error("secondary buffer enable wrong");
    chk_auto_pref: assert property (
        (synthAAuto -> synthAUseSecondary != $past(primaryAvailable))
        && (synthBAuto -> synthBUseSecondary != $past(primaryAvailable)))
        else $error("automatic mode source wrong");
    chk_pin_a: assert property ($past(rst_n)
        && $past(selMirror[1:0]) == RISS_SEL_PIN |-> synthAAuto ==
        ($past(refChoicePin) inside {RISS_PIN_MID, RISS_PIN_HIGH})
        && (synthAAuto || !synthAUseSecondary))
        else $error("synth A pin decode wrong");
    chk_pin_b: assert property ($past(rst_n)
        && $past(selMirror[3:2]) == RISS_SEL_PIN
        |-> synthBAuto == ($past(refChoicePin) == RISS_PIN_HIGH)
        && (synthBAuto || synthBUseSecondary))
        else $error("synth B pin decode wrong");
    chk_forced_sec: assert property ($past(rst_n)
        && $past(selMirror) == 4'hF |-> synthAUseSecondary
        && synthBUseSecondary && !synthAAuto && !synthBAuto)
        else $error("forced secondary wrong");
endmodule
bind riss_top riss_checker chk (.mclk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_waitrequest,
    .refChoicePin, .primaryAvailable, .firstStatusEdgeRate,
    .secondStatusEdgeRate, .firstStatusSlow, .secondStatusSlow,
    .primaryBufferMode, .secondaryBufferMode, .primaryBufferOn,
    .secondaryBufferOn, .synthAUseSecondary, .synthBUseSecondary,
    .synthAAuto, .synthBAuto);

// File: test/riss_ref_source.sv
// Far-side model: primary clock health and three-level select pin
`timescale 1ns/1ns
module riss_ref_source
(
    input wire logic mclk,
    input wire logic [1:0] wantPin,
    input wire logic wantGood,
    output logic [1:0] refChoicePin = 2'h0,
    output logic primaryAvailable = 1'b1
);
    // Board levels settle on an edge, never mid-cycle
    always @(posedge mclk)
    begin
        refChoicePin <= wantPin;
        primaryAvailable <= wantGood;
    end
endmodule

// File: test/testbench.sv
// Self-checking bench for the reference select block
`timescale 1ns/1ns
module testbench
    import riss_pkg::*;
;
    logic mclk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0] avs_byteenable = 4'h0;
    logic avs_waitrequest, primaryAvailable, wantGood = 1'b1;
    logic [1:0] avs_response, refChoicePin, rsp, wantPin = 2'h0;
    logic [1:0] firstStatusEdgeRate, secondStatusEdgeRate;
    logic [1:0] primaryBufferMode, secondaryBufferMode;
    logic firstStatusSlow, secondStatusSlow, primaryBufferOn;
    logic secondaryBufferOn, synthAUseSecondary, synthBUseSecondary;
    logic synthAAuto, synthBAuto;
    int error_cnt = 0, comparisons = 0, cycles = 0, slewReg, inselReg;
    riss_top DUT (.mclk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .avs_response, .refChoicePin, .primaryAvailable,
        .firstStatusEdgeRate, .secondStatusEdgeRate, .firstStatusSlow,
        .secondStatusSlow, .primaryBufferMode, .secondaryBufferMode,
        .primaryBufferOn, .secondaryBufferOn, .synthAUseSecondary,
        .synthBUseSecondary, .synthAAuto, .synthBAuto);
    riss_ref_source farSide (.mclk, .wantPin, .wantGood, .refChoicePin,
        .primaryAvailable);
    initial
        forever #2 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    task print_verdict();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    // Waits for the answer; only the cycle ceiling ends a hung access
    task automatic bus(input logic wr, input logic [9:0] a,
        input logic [31:0] d, input logic [3:0] be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        {avs_write, avs_read} <= {wr, !wr};
        do
        begin
            @(posedge mclk);
        end
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        {avs_write, avs_read} <= 2'h0;
    endtask
    // Model answer {auto, useSecondary}; pin code 3 reads as low
    function automatic logic [1:0] mdl(int sel, int pin, int ok, int b);
        case (sel)
            0: return {1'b1, ok == 0};
            1:
                if (b ? pin == 2 : (pin == 1 || pin == 2))
                    return {1'b1, ok == 0};
                else
                    return {1'b0, b != 0};
            2: return 2'h0;
            default: return 2'h1;
        endcase
    endfunction
    initial
    begin
        void'($urandom(34972));
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        bus(0, RISS_ADDR_SLEW, 0, 4'hF);
        check(rd, 0);
        bus(0, RISS_ADDR_INSEL, 0, 4'hF);
        check(rd, 32'h95);
        for (int i = 0; i < 4; i++)
        begin
            slewReg = (i % 2) * 2 + (i / 2) * 8;
            bus(1, RISS_ADDR_SLEW, ($urandom & 32'hF0) | slewReg, 4'h1);
            bus(0, RISS_ADDR_SLEW, 0, 4'hF);
            check(rd, slewReg);
            check({secondStatusSlow, firstStatusSlow},
                i);
            check({secondStatusEdgeRate, firstStatusEdgeRate},
                slewReg);
        end
        bus(1, RISS_ADDR_SLEW, 32'h2, 4'h0);
        bus(0, RISS_ADDR_SLEW, 0, 4'hF);
        check(rd, slewReg);
        for (int i = 0; i < 16; i++)
        begin
            inselReg = ($urandom & 32'hF0) | i;
            bus(1, RISS_ADDR_INSEL, inselReg, 4'hF);
            @(posedge mclk);
            check({secondaryBufferOn, primaryBufferOn},
                {inselReg[7:6] != 2'h3,
                inselReg[5:4] < 2'h2});
            check({secondaryBufferMode, primaryBufferMode},
                inselReg >> 4);
            for (int k = 0; k < 8; k++)
            begin
                wantPin <= k[1:0];
                wantGood <= k[2];
                repeat (3) @(posedge mclk);
                check({synthAAuto, synthAUseSecondary},
                    mdl(i % 4, k % 4, k / 4, 0));
                check({synthBAuto, synthBUseSecondary},
                    mdl(i / 4, k % 4, k / 4, 1));
            end
            bus(0, RISS_ADDR_STATE, 0, 4'hF);
            check(rd, {mdl(i / 4, 3, 1, 1), mdl(i % 4, 3, 1, 0)});
        end
        bus(1, RISS_ADDR_STATE, 32'hF, 4'hF);
        check(rsp, 2'h2);
        bus(0, 10'h3FC, 0, 4'hF);
        check({rsp, rd[29:0]}, {2'h3, 30'h0});
        print_verdict();
    end
endmodule
